// ==== fpc_seq.sv ====
// Fire pump stop, test, overspeed and dump valve sequencer
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "fpc_map.svh"
module fpc_seq #(
	parameter int TICK_CYC  = `FP_SEC_CYC,
	parameter int MIN_RUN_S = `FP_MIN_RUN_S,
	parameter int CRANK_S   = `FP_CRANK_S,
	parameter int WEEK_S    = `FP_WEEK_S
) (
	input  wire logic                  sys_clk,
	input  wire logic                  resetn,
	input  wire fpc_pkg::fpc_pin_t     pins,
	output      fpc_pkg::fpc_out_t     outs,
	input  wire fpc_pkg::fpc_axi_req_t axi_req,
	output      fpc_pkg::fpc_axi_rsp_t axi_rsp
);

	fpc_pkg::fpc_state_t   s_r;
	fpc_pkg::fpc_state_t   s_nxt;
	fpc_pkg::fpc_pin_t     p;
	logic                  lock;
	logic                  add_go;
	logic                  gen_cause;
	logic                  test_act;
	logic                  test_go;
	logic                  start_req;
	logic                  cause_new;
	logic                  pb_stop;
	logic                  auto_stop;
	logic                  prot_stop;
	logic                  test_done;
	logic                  test_stop;
	logic [`FP_SEC_W-1:0]  dur_eff;

	////////////////////////////////////////////////////////////////////////////
	// Cause decoding
	assign p         = s_r.pin_s2;
	assign lock      = s_r.ctrl[`FP_C_DSTBY] & s_r.ctrl[`FP_C_LOCKOUT]
		& s_r.ctrl[`FP_C_ADD]; // R19
	assign add_go    = s_r.ctrl[`FP_C_ADD] & ~lock
		& (p.add_contact ^ s_r.ctrl[`FP_C_NC]); // R17
	// Own drain still seen through the pin pipeline for three cycles after it shuts
	assign gen_cause = p.deluge_open | add_go
		| (p.press_low & ~s_r.outs.drain_sol & ~(|s_r.drain_d));
	assign test_act  = s_r.ptest | s_r.mtest;
	assign test_go   = test_act & ~s_r.prot_shut
		& (s_r.ctrl[`FP_C_NONPR] | p.press_low); // R12
	assign start_req = (gen_cause | s_r.man_lat | test_go) & ~p.main_off & ~lock;
	assign cause_new = gen_cause & ~s_r.cause_d;
	assign pb_stop   = p.stop_pb & ~gen_cause & ~p.local_start & ~p.remote_start; // R1
	assign auto_stop = s_r.ctrl[`FP_C_AUTO] & ~s_r.ctrl[`FP_C_ADD] & s_r.auto_lat
		& s_r.minrun_done & ~gen_cause & ~s_r.man_lat & ~test_act; // R5 R7 R18
	assign prot_stop = (p.high_temp | p.low_oil) & test_act & ~gen_cause
		& ~s_r.man_lat & ~s_r.auto_lat & ~s_r.prot_ovr
		& ~s_r.ctrl[`FP_C_ADD]; // R10 R11
	assign dur_eff   = `FP_SEC_W'(MIN_RUN_S) + {4'h0, s_r.dur}; // R13
	assign test_done = s_r.ptest & (s_r.test_cnt >= dur_eff);
	assign test_stop = test_done & ~gen_cause & ~s_r.man_lat & ~s_r.auto_lat
		& ~s_r.mtest & ~s_r.ctrl[`FP_C_ADD];

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic        stop_now;
		logic        use1;
		logic [31:0] wm;
		logic [31:0] wv;
		stop_now = 1'b0;
		use1     = 1'b0;
		wm       = '0;
		wv       = '0;
		s_nxt    = s_r;
		s_nxt.pin_s1  = pins;
		s_nxt.pin_s2  = s_r.pin_s1;
		s_nxt.mo_d    = p.main_off;
		s_nxt.cause_d = gen_cause;
		s_nxt.drain_d = {s_r.drain_d[1:0], s_r.outs.drain_sol};
		s_nxt.tick    = (s_r.tick_cnt == `FP_TICK_W'(TICK_CYC - 1));
		s_nxt.tick_cnt = s_nxt.tick ? '0 : s_r.tick_cnt + 1'b1;

		// Start latches
		if (p.local_start | p.remote_start)
			s_nxt.man_lat = 1'b1; // R4 R7
		if (p.local_start | p.stop_pb) begin
			s_nxt.ptest = 1'b0; // R16
		end
		if (p.stop_pb)
			s_nxt.mtest = 1'b0; // R16
		if (p.test_btn & ~p.main_off)
			s_nxt.mtest = 1'b1; // R12

		// Weekly program timer
		if (!s_r.ctrl[`FP_C_PTEST]) begin
			s_nxt.week_cnt = '0; // R14
			s_nxt.ptest    = 1'b0; // R14
		end else if (s_r.tick) begin
			if (s_r.week_cnt == `FP_SEC_W'(WEEK_S - 1)) begin
				s_nxt.week_cnt = '0;
				if (s_r.st == fpc_pkg::FPC_IDLE && !s_r.man_lat && !p.main_off
					&& !p.local_start && !p.stop_pb) begin
					s_nxt.ptest    = 1'b1; // R13 R16
					s_nxt.test_cnt = '0;
				end
			end else begin
				s_nxt.week_cnt = s_r.week_cnt + 1'b1;
			end
		end
		if (s_r.ptest && s_r.tick)
			s_nxt.test_cnt = s_r.test_cnt + 1'b1;
		if (test_done)
			s_nxt.ptest = 1'b0; // R13

		// Minimum run timer
		if (cause_new || s_r.st != fpc_pkg::FPC_RUN)
			s_nxt.run_cnt = '0; // R24
		else if (s_r.tick && p.eng_run && !s_r.minrun_done)
			s_nxt.run_cnt = s_r.run_cnt + 1'b1; // R24
		s_nxt.minrun_done = (s_nxt.run_cnt >= `FP_SEC_W'(MIN_RUN_S)); // R24

		// Sequencer
		unique case (s_r.st)
			fpc_pkg::FPC_IDLE: begin
				s_nxt.fs_seen  = 1'b0;
				s_nxt.attempts = '0;
				s_nxt.sec_cnt  = '0;
				s_nxt.batt     = 1'b0;
				if (start_req) begin
					s_nxt.auto_lat = gen_cause;
					if (s_r.prot_shut)
						s_nxt.prot_ovr = 1'b1; // R11
					if (s_r.ctrl[`FP_C_ELEC])
						s_nxt.st = fpc_pkg::FPC_RUN; // R21 R22
					else
						s_nxt.st = fpc_pkg::FPC_CRANK; // R20 R22
				end
			end
			fpc_pkg::FPC_CRANK: begin
				if (p.eng_run) begin
					s_nxt.st = fpc_pkg::FPC_RUN;
				end else if (s_r.tick) begin
					if (s_r.sec_cnt == `FP_SEC_W'(CRANK_S - 1)) begin
						s_nxt.sec_cnt  = '0;
						s_nxt.st       = fpc_pkg::FPC_REST;
						s_nxt.attempts = s_r.attempts + 1'b1;
						s_nxt.batt     = ~s_r.batt; // R23
					end else begin
						s_nxt.sec_cnt = s_r.sec_cnt + 1'b1;
					end
				end
				stop_now = pb_stop;
			end
			fpc_pkg::FPC_REST: begin
				if (p.eng_run) begin
					s_nxt.st = fpc_pkg::FPC_RUN;
				end else if (s_r.tick) begin
					if (s_r.sec_cnt == `FP_SEC_W'(CRANK_S - 1)) begin
						s_nxt.sec_cnt = '0; // R23
						if (s_r.attempts == `FP_CRANK_N)
							s_nxt.st = fpc_pkg::FPC_FAIL;
						else
							s_nxt.st = fpc_pkg::FPC_CRANK;
					end else begin
						s_nxt.sec_cnt = s_r.sec_cnt + 1'b1;
					end
				end
				stop_now = pb_stop;
			end
			fpc_pkg::FPC_RUN: begin
				if (p.full_speed)
					s_nxt.fs_seen = 1'b1; // R20 R21
				if (gen_cause) begin
					s_nxt.auto_lat = 1'b1; // R15
					s_nxt.ptest    = 1'b0; // R15
				end
				if (prot_stop)
					s_nxt.prot_shut = 1'b1; // R10
				stop_now = pb_stop | auto_stop | prot_stop | test_stop; // R1 R5
			end
			fpc_pkg::FPC_FAIL: begin
				s_nxt.st = fpc_pkg::FPC_FAIL;
			end
			fpc_pkg::FPC_TRIP: begin
				if (p.main_off && !s_r.mo_d && !p.overspeed)
					s_nxt.st = fpc_pkg::FPC_IDLE; // R9
			end
			default: begin
				s_nxt.st = fpc_pkg::FPC_IDLE;
			end
		endcase

		if (lock && s_r.st != fpc_pkg::FPC_TRIP)
			stop_now = 1'b1; // R19
		if (stop_now) begin
			s_nxt.st       = fpc_pkg::FPC_IDLE; // R2
			s_nxt.man_lat  = 1'b0;
			s_nxt.auto_lat = 1'b0;
		end
		if (p.main_off && s_r.st != fpc_pkg::FPC_TRIP) begin
			s_nxt.st       = fpc_pkg::FPC_IDLE; // R3
			s_nxt.man_lat  = 1'b0;
			s_nxt.auto_lat = 1'b0;
			s_nxt.ptest    = 1'b0;
			s_nxt.mtest    = 1'b0;
		end
		if (p.overspeed)
			s_nxt.st = fpc_pkg::FPC_TRIP; // R8
		if (!s_nxt.ptest && !s_nxt.mtest) begin
			s_nxt.prot_shut = 1'b0;
			s_nxt.prot_ovr  = 1'b0;
		end

		// Outputs from the next state
		use1 = p.batt1_ok & (~s_nxt.batt | ~p.batt2_ok); // R23
		s_nxt.outs.run = (s_nxt.st == fpc_pkg::FPC_CRANK)
			| (s_nxt.st == fpc_pkg::FPC_REST) | (s_nxt.st == fpc_pkg::FPC_RUN); // R8
		s_nxt.outs.crank1 = (s_nxt.st == fpc_pkg::FPC_CRANK) & use1; // R8 R23
		s_nxt.outs.crank2 = (s_nxt.st == fpc_pkg::FPC_CRANK) & ~use1
			& p.batt2_ok; // R8 R23
		s_nxt.outs.os_alarm      = (s_nxt.st == fpc_pkg::FPC_TRIP); // R8
		s_nxt.outs.fail_alarm    = (s_nxt.st == fpc_pkg::FPC_FAIL);
		s_nxt.outs.auto_stop_led = s_r.ctrl[`FP_C_AUTO]; // R6
		s_nxt.outs.drain_sol     = (s_nxt.ptest | s_nxt.mtest)
			& ~s_r.ctrl[`FP_C_NONPR] & ~s_nxt.prot_shut; // R12
		s_nxt.outs.dump_valve    = (s_nxt.st == fpc_pkg::FPC_CRANK)
			| (s_nxt.st == fpc_pkg::FPC_REST)
			| ((s_nxt.st == fpc_pkg::FPC_RUN) & ~s_nxt.fs_seen); // R20 R21 R22
		s_nxt.outs.lockout_led    = lock; // R19
		s_nxt.outs.lockout_remote = lock; // R19

		// AXI4-Lite write
		if (axi_req.awvalid && !s_r.aw_have && !s_r.bvalid) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.awaddr  = axi_req.awaddr;
		end
		if (axi_req.wvalid && !s_r.w_have && !s_r.bvalid) begin
			s_nxt.w_have = 1'b1;
			s_nxt.wdata  = axi_req.wdata;
			s_nxt.wstrb  = axi_req.wstrb;
		end
		if (s_r.bvalid && axi_req.bready)
			s_nxt.bvalid = 1'b0;
		if (s_r.aw_have && s_r.w_have) begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have  = 1'b0;
			s_nxt.bvalid  = 1'b1;
			s_nxt.bresp   = `FP_OKAY;
			wm = {{8{s_r.wstrb[3]}}, {8{s_r.wstrb[2]}},
				{8{s_r.wstrb[1]}}, {8{s_r.wstrb[0]}}};
			unique case (s_r.awaddr)
				`FP_ADR_CTRL: begin
					wv = ({23'h0, s_r.ctrl} & ~wm) | (s_r.wdata & wm);
					s_nxt.ctrl = wv[`FP_CTRL_W-1:0];
					if (s_r.ctrl[`FP_C_LOCK]) begin
						s_nxt.ctrl[`FP_C_AUTO] = s_r.ctrl[`FP_C_AUTO]; // R6
						s_nxt.ctrl[`FP_C_LOCK] = 1'b1; // R6
					end
				end
				`FP_ADR_DUR: begin
					wv = ({16'h0, s_r.dur} & ~wm) | (s_r.wdata & wm);
					s_nxt.dur = wv[`FP_DUR_W-1:0];
				end
				default: begin
					s_nxt.bresp = `FP_SLVERR;
				end
			endcase
		end

		// AXI4-Lite read
		if (s_r.rvalid && axi_req.rready)
			s_nxt.rvalid = 1'b0;
		if (axi_req.arvalid && !s_r.rvalid) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp  = `FP_OKAY;
			unique case (axi_req.araddr)
				`FP_ADR_CTRL: s_nxt.rdata = {23'h0, s_r.ctrl};
				`FP_ADR_DUR:  s_nxt.rdata = {16'h0, s_r.dur};
				`FP_ADR_STAT: s_nxt.rdata = {17'h0, s_r.fs_seen, s_r.attempts,
					s_r.batt, s_r.minrun_done, s_r.prot_ovr, s_r.prot_shut,
					s_r.mtest, s_r.ptest, s_r.auto_lat, s_r.man_lat, s_r.st};
				`FP_ADR_RUNT: s_nxt.rdata = {12'h0, s_r.run_cnt};
				default: begin
					s_nxt.rdata = '0;
					s_nxt.rresp = `FP_SLVERR;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign outs            = s_r.outs;
	assign axi_rsp.awready = ~s_r.aw_have & ~s_r.bvalid;
	assign axi_rsp.wready  = ~s_r.w_have & ~s_r.bvalid;
	assign axi_rsp.bvalid  = s_r.bvalid;
	assign axi_rsp.bresp   = s_r.bresp;
	assign axi_rsp.arready = ~s_r.rvalid;
	assign axi_rsp.rvalid  = s_r.rvalid;
	assign axi_rsp.rdata   = s_r.rdata;
	assign axi_rsp.rresp   = s_r.rresp;

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence crank_entry;
		s_r.st == fpc_pkg::FPC_IDLE ##1 s_r.st == fpc_pkg::FPC_CRANK;
	endsequence
	sequence crank_rest;
		s_r.st == fpc_pkg::FPC_CRANK ##1 s_r.st == fpc_pkg::FPC_REST;
	endsequence

	os_trip_a: // R8
	assert property (p.overspeed |=> s_r.st == fpc_pkg::FPC_TRIP && !outs.run
		&& !outs.crank1 && !outs.crank2 && outs.os_alarm)
		else $error("overspeed did not trip");
	trip_hold_a: // R9
	assert property (s_r.st == fpc_pkg::FPC_TRIP
		&& (p.overspeed || !p.main_off || s_r.mo_d) |=> s_r.st == fpc_pkg::FPC_TRIP)
		else $error("trip cleared early");
	main_off_a: // R3
	assert property (outs.run && p.main_off && !p.overspeed
		|=> s_r.st == fpc_pkg::FPC_IDLE && !outs.run)
		else $error("main switch did not stop");
	pb_hold_a: // R1
	assert property (s_r.st == fpc_pkg::FPC_RUN && p.stop_pb && gen_cause
		&& !p.main_off && !p.overspeed && !lock |=> s_r.st == fpc_pkg::FPC_RUN)
		else $error("button stopped with cause");
	pb_ready_a: // R2
	assert property (s_r.st == fpc_pkg::FPC_RUN && pb_stop && !p.main_off
		&& !p.overspeed |=> s_r.st == fpc_pkg::FPC_IDLE && !s_r.man_lat && !s_r.auto_lat)
		else $error("button stop not back to auto");
	min_run_a: // R5
	assert property (s_r.st == fpc_pkg::FPC_RUN && !s_r.minrun_done && !p.stop_pb
		&& !p.main_off && !p.overspeed && !test_act && !lock
		|=> s_r.st == fpc_pkg::FPC_RUN)
		else $error("stopped before minimum run");
	add_hold_a: // R18
	assert property (s_r.st == fpc_pkg::FPC_RUN && s_r.ctrl[`FP_C_ADD] && !p.stop_pb
		&& !p.main_off && !p.overspeed && !lock |=> s_r.st == fpc_pkg::FPC_RUN)
		else $error("additive pump stopped itself");
	dump_open_a: // R20
	assert property (crank_entry |-> outs.dump_valve)
		else $error("dump valve shut at crank");
	dump_hold_a: // R21
	assert property (s_r.st == fpc_pkg::FPC_RUN && !s_r.fs_seen |-> outs.dump_valve)
		else $error("dump valve shut before speed");
	batt_alt_a: // R23
	assert property (crank_rest |-> s_r.batt != $past(s_r.batt))
		else $error("battery not alternated");
	test_yield_a: // R15
	assert property (s_r.st == fpc_pkg::FPC_RUN && s_r.ptest && gen_cause
		&& !p.stop_pb && !p.main_off && !p.overspeed && !lock
		|=> s_r.st == fpc_pkg::FPC_RUN && !s_r.ptest && s_r.auto_lat && outs.run)
		else $error("test did not yield to demand");

endmodule : fpc_seq

// ==== fpc_map.svh ====
// Constants of the fire pump stop, test, trip and dump valve sequencer
// Functional notes
// R1 - Stop button acts only when causes normal
// R2 - After button stop return to automatic
// R3 - Main switch off stops unconditionally
// R4 - Remote station can never stop engine
// R5 - Auto stop needs causes normal, minimum run
// R6 - Lockable auto stop disable with indicator
// R7 - Auto stop spares local and remote starts
// R8 - Overspeed kills run, cranking, latches alarm
// R9 - Overspeed reset: engine first, then switch off
// R10 - Temperature and oil stops only in bare test
// R11 - Cause after test shutdown restarts, overrides
// R12 - Test start opens pressure drain solenoid
// R13 - Weekly test runs at least minimum time
// R14 - Setting disables the weekly test timer
// R15 - Real demand turns test into full run
// R16 - Manual operation overrides the test timer
// R17 - Additive pump starts on contact, either sense
// R18 - Additive pump stops only by hand
// R19 - Duty standby lockout stops additive pump
// R20 - Diesel dump valve opens by first crank
// R21 - Electric dump valve opens with motor power
// R22 - Dump valve also sequenced on manual start
// R23 - Cranking alternates batteries, equal crank rest
// R24 - Run timer from running, restarts on cause
`ifndef FPC_MAP_SVH
`define FPC_MAP_SVH
`define FP_CLK_MHZ     250
`define FP_SEC_CYC     (`FP_CLK_MHZ * 1000000)
`define FP_MIN_RUN_MIN 30
`define FP_MIN_RUN_S   (`FP_MIN_RUN_MIN * 60)
`define FP_CRANK_S     15
`define FP_CRANK_N     3'h6
`define FP_WEEK_DAYS   7
`define FP_WEEK_S      (`FP_WEEK_DAYS * 86400)
`define FP_ADR_CTRL    8'h00
`define FP_ADR_DUR     8'h04
`define FP_ADR_STAT    8'h08
`define FP_ADR_RUNT    8'h0C
`define FP_C_AUTO      0
`define FP_C_LOCK      1
`define FP_C_PTEST     2
`define FP_C_ELEC      3
`define FP_C_ADD       4
`define FP_C_NC        5
`define FP_C_DSTBY     6
`define FP_C_LOCKOUT   7
`define FP_C_NONPR     8
`define FP_CTRL_W      9
`define FP_DUR_W       16
`define FP_SEC_W       20
`define FP_TICK_W      28
`define FP_OKAY        2'h0
`define FP_SLVERR      2'h2
`endif

// ==== fpc_pkg.sv ====
// Shared types of the fire pump sequencer
`include "fpc_map.svh"
package fpc_pkg;
	typedef enum logic [2:0] {
		FPC_IDLE  = 3'h0,
		FPC_CRANK = 3'h1,
		FPC_REST  = 3'h2,
		FPC_RUN   = 3'h3,
		FPC_FAIL  = 3'h4,
		FPC_TRIP  = 3'h5
	} fpc_st_t;

	typedef struct packed {
		logic main_off, stop_pb, local_start, remote_start;
		logic press_low, deluge_open, add_contact, test_btn;
		logic overspeed, eng_run, full_speed, high_temp, low_oil;
		logic batt1_ok, batt2_ok;
	} fpc_pin_t;

	typedef struct packed {
		logic run, crank1, crank2, os_alarm, fail_alarm;
		logic auto_stop_led, drain_sol, dump_valve;
		logic lockout_led, lockout_remote;
	} fpc_out_t;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready, arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} fpc_axi_req_t;

	typedef struct packed {
		logic        awready, wready, bvalid;
		logic [1:0]  bresp;
		logic        arready, rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} fpc_axi_rsp_t;

	typedef struct packed {
		fpc_pin_t              pin_s1, pin_s2;
		fpc_st_t               st;
		logic [`FP_TICK_W-1:0] tick_cnt;
		logic                  tick, mo_d, cause_d, batt;
		logic [`FP_SEC_W-1:0]  sec_cnt, run_cnt, week_cnt, test_cnt;
		logic [2:0]            attempts;
		logic                  man_lat, auto_lat, ptest, mtest;
		logic                  prot_shut, prot_ovr, fs_seen, minrun_done;
		logic [2:0]            drain_d;
		logic [`FP_CTRL_W-1:0] ctrl;
		logic [`FP_DUR_W-1:0]  dur;
		logic                  aw_have, w_have, bvalid, rvalid;
		logic [7:0]            awaddr;
		logic [31:0]           wdata, rdata;
		logic [3:0]            wstrb;
		logic [1:0]            bresp, rresp;
		fpc_out_t              outs;
	} fpc_state_t;
endpackage : fpc_pkg

// ==== fpc_engine_model.sv ====
// Engine, motor and pressure line model facing the sequencer
`timescale 1ns/1ns
module fpc_engine_model (
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic run,
	input  wire logic drain,
	input  wire logic slow,
	output logic      eng_run,
	output logic      full_speed,
	output logic      press_drain
);
	int cnt;

	////////////////////////////////////////////////////////////////////////////////
	// Speed builds up while powered, collapses at once without power
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 0;
			eng_run <= 1'b0;
			full_speed <= 1'b0;
			press_drain <= 1'b0;
		end else begin
			press_drain <= drain;
			cnt <= run ? cnt + 1 : 0;
			eng_run <= run && cnt >= (slow ? 20 : 4);
			full_speed <= run && cnt >= (slow ? 40 : 12);
		end
	end
endmodule : fpc_engine_model

// ==== fire_pump_stop_test_sequencer_test.sv ====
// Self-checking bench of the fire pump sequencer
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin errors++; \
	$display("wrong value %s exp %h got %h", n, e, s); end end
`define UNTIL(c, n) begin k = 0; while (!(c) && k < n) begin @(posedge sys_clk); k++; end end
module fire_pump_stop_test_sequencer_test;
	logic                  sys_clk = 1'b0;
	logic                  resetn  = 1'b0;
	logic                  slow    = 1'b0;
	logic                  er, fs, pd;
	fpc_pkg::fpc_pin_t     p, pins;
	fpc_pkg::fpc_out_t     outs;
	fpc_pkg::fpc_axi_req_t rq;
	fpc_pkg::fpc_axi_rsp_t rs;
	int                    errors = 0, compares = 0, cyc = 0, k, t0;
	logic [31:0]           seed = 32'hE365BC0F, d, v;
	logic [1:0]            r;

	always #2 sys_clk = ~sys_clk;
	always_comb begin
		pins = p;
		pins.eng_run = er;
		pins.full_speed = fs;
		pins.press_low = p.press_low | pd;
	end
	fpc_seq #(.TICK_CYC(10), .MIN_RUN_S(5), .CRANK_S(3), .WEEK_S(40)) uut (.sys_clk(sys_clk),
		.resetn(resetn), .pins(pins), .outs(outs), .axi_req(rq), .axi_rsp(rs));
	fpc_engine_model eng (.sys_clk(sys_clk), .resetn(resetn), .run(outs.run),
		.drain(outs.drain_sol), .slow(slow), .eng_run(er), .full_speed(fs), .press_drain(pd));

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic ed(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : ed
	task automatic rst();
		@(posedge sys_clk);
		resetn <= 1'b0;
		ed(20);
		resetn <= 1'b1;
		ed(2);
	endtask : rst
	task automatic mo();
		p.main_off <= 1'b1;
		ed(5);
		p.main_off <= 1'b0;
		ed(5);
	endtask : mo
	task automatic aw(input logic [7:0] a, input logic [31:0] w);
		@(posedge sys_clk);
		rq.awvalid <= 1'b1;
		rq.awaddr <= a;
		rq.wvalid <= 1'b1;
		rq.wdata <= w;
		rq.bready <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
			if (rq.awvalid && rs.awready) rq.awvalid <= 1'b0;
			if (rq.wvalid && rs.wready) rq.wvalid <= 1'b0;
		end while (!rs.bvalid && k < 50);
		rq.bready <= 1'b0;
		r = rs.bresp;
	endtask : aw
	task automatic ar(input logic [7:0] a);
		@(posedge sys_clk);
		rq.arvalid <= 1'b1;
		rq.araddr <= a;
		rq.rready <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
			if (rq.arvalid && rs.arready) rq.arvalid <= 1'b0;
		end while (!rs.rvalid && k < 50);
		rq.rready <= 1'b0;
		d = rs.rdata;
		r = rs.rresp;
	endtask : ar
	task automatic test_done();
		if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	initial begin
		p = '0;
		p.batt1_ok = 1'b1;
		p.batt2_ok = 1'b1;
		rq = '0;
		rq.wstrb = 4'hF;
		rst();
		`CHK("outs", 10'h000, outs)
		ar(8'h40);
		`CHK("rresp", 2'h2, r)
		aw(8'h08, 32'h0000FFFF);
		`CHK("bresp", 2'h2, r)
		repeat (4) begin
			v = xs();
			aw(8'h04, v);
			ar(8'h04);
			`CHK("dur", {16'h0000, v[15:0]}, d)
		end
		aw(8'h04, 32'h00000000);
		p.press_low <= 1'b1;
		`UNTIL(outs.run === 1'b1, 10)
		`CHK("start", 3'h7, {outs.crank1, outs.dump_valve, outs.run})
		`UNTIL(er === 1'b1, 60)
		`CHK("dump", 1'b1, outs.dump_valve)
		`UNTIL(fs === 1'b1, 60)
		ed(4);
		`CHK("dump", 2'h1, {outs.dump_valve, outs.run})
		p.remote_start <= 1'b1;
		ed(2);
		p.remote_start <= 1'b0;
		p.stop_pb <= 1'b1;
		ed(6);
		`CHK("run", 1'b1, outs.run)
		p.stop_pb <= 1'b0;
		p.press_low <= 1'b0;
		ed(4);
		p.stop_pb <= 1'b1;
		ed(5);
		p.stop_pb <= 1'b0;
		`CHK("run", 1'b0, outs.run)
		p.press_low <= 1'b1;
		`UNTIL(outs.run === 1'b1, 10)
		`CHK("restart", 1'b1, outs.run)
		p.main_off <= 1'b1;
		ed(4);
		`CHK("estop", 1'b0, outs.run)
		p.main_off <= 1'b0;
		p.press_low <= 1'b0;
		ed(4);
		aw(8'h00, 32'h00000001);
		ed(1);
		`CHK("led", 1'b1, outs.auto_stop_led)
		p.press_low <= 1'b1;
		`UNTIL(er === 1'b1, 60)
		t0 = cyc;
		p.press_low <= 1'b0;
		`UNTIL(outs.run === 1'b0, 200)
		`CHK("autostop", 2'h1, {outs.run, (cyc - t0) >= 40})
		p.local_start <= 1'b1;
		ed(2);
		p.local_start <= 1'b0;
		ed(150);
		`CHK("local", 1'b1, outs.run)
		mo();
		aw(8'h00, 32'h00000003);
		aw(8'h00, 32'h00000000);
		ar(8'h00);
		`CHK("lock", 2'h3, d[1:0])
		rst();
		p.press_low <= 1'b1;
		`UNTIL(er === 1'b1, 60)
		p.overspeed <= 1'b1;
		ed(4);
		`CHK("trip", 4'h1, {outs.run, outs.crank1, outs.crank2, outs.os_alarm})
		p.press_low <= 1'b0;
		mo();
		`CHK("early", 1'b1, outs.os_alarm)
		p.overspeed <= 1'b0;
		ed(4);
		`CHK("held", 1'b1, outs.os_alarm)
		mo();
		`CHK("clear", 1'b0, outs.os_alarm)
		p.test_btn <= 1'b1;
		ed(2);
		p.test_btn <= 1'b0;
		`UNTIL(er === 1'b1, 60)
		`CHK("drain", 2'h3, {outs.drain_sol, outs.run})
		p.high_temp <= 1'b1;
		ed(5);
		`CHK("tempstop", 1'b0, outs.run)
		p.deluge_open <= 1'b1;
		`UNTIL(outs.run === 1'b1, 10)
		ed(40);
		`CHK("override", 1'b1, outs.run)
		p.high_temp <= 1'b0;
		p.deluge_open <= 1'b0;
		mo();
		ed(450);
		`CHK("noweek", 1'b0, outs.run)
		aw(8'h00, 32'h00000004);
		`UNTIL(outs.run === 1'b1, 500)
		t0 = cyc;
		`CHK("week", 1'b1, outs.run)
		`UNTIL(outs.run === 1'b0, 300)
		`CHK("weeklen", 1'b1, (cyc - t0) >= 40)
		`UNTIL(outs.run === 1'b1, 500)
		p.deluge_open <= 1'b1;
		ed(200);
		`CHK("demand", 1'b1, outs.run)
		aw(8'h00, 32'h00000000);
		p.deluge_open <= 1'b0;
		mo();
		slow <= 1'b1;
		aw(8'h00, 32'h00000008);
		p.press_low <= 1'b1;
		`UNTIL(outs.run === 1'b1, 10)
		`CHK("edump", 1'b1, outs.dump_valve)
		`UNTIL(fs === 1'b1, 80)
		ed(4);
		`CHK("eclose", 1'b0, outs.dump_valve)
		p.press_low <= 1'b0;
		mo();
		slow <= 1'b0;
		aw(8'h00, 32'h00000000);
		p.local_start <= 1'b1;
		`UNTIL(outs.run === 1'b1, 10)
		p.local_start <= 1'b0;
		`CHK("mdump", 1'b1, outs.dump_valve)
		mo();
		for (int i = 0; i < 2; i++) begin
			aw(8'h00, 32'h00000011 | (i << 5));
			p.add_contact <= !i[0];
			`UNTIL(outs.run === 1'b1, 10)
			`CHK("addstart", 1'b1, outs.run)
			p.add_contact <= i[0];
			ed(150);
			`CHK("addkeep", 1'b1, outs.run)
			aw(8'h00, 32'h000000D1 | (i << 5));
			ed(4);
			`CHK("lockout", 3'h6, {outs.lockout_led, outs.lockout_remote, outs.run})
			aw(8'h00, 32'h00000000);
			mo();
		end
		test_done();
	end
endmodule : fire_pump_stop_test_sequencer_test
